// [flsr_map.vh]
// Constants of the flash status register bank: commands, masks,
// reset values, parameter-table words and timing.
// Assumes one 100 MHz core clock; included by bare name.
`ifndef FLSR_MAP_VH
`define FLSR_MAP_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define FLSR_CMD_RD_SR1 8'h05
`define FLSR_CMD_RD_SR2 8'h35
`define FLSR_CMD_RD_SR3 8'h15
`define FLSR_CMD_WR_SR1 8'h01
`define FLSR_CMD_WR_SR2 8'h31
`define FLSR_CMD_WR_SR3 8'h11
`define FLSR_CMD_WRITE_ENABLE_COMMAND 8'h06
`define FLSR_CMD_WRDIS 8'h04
`define FLSR_CMD_VOL_WEN 8'h50
`define FLSR_CMD_RD_PARAM 8'h5a
`define FLSR_CMD_SUSPEND 8'h75
`define FLSR_CMD_RESUME 8'h7a
`define FLSR_CMD_RST_EN 8'h66
`define FLSR_CMD_RST 8'h99

// ----------------------------------------
// Status bit positions and masks
// ----------------------------------------
`define FLSR_BIT_BUSY 0
`define FLSR_BIT_WEL 1
`define FLSR_BIT_BP_LO 2
`define FLSR_BIT_SRP_LO 7
`define FLSR_BIT_SRP_HI 8
`define FLSR_BIT_QE 9
`define FLSR_BIT_PROGRAM_SUSPENDED 10
`define FLSR_BIT_IRL_LO 11
`define FLSR_BIT_CMP 14
`define FLSR_BIT_ERASE_SUSPENDED 15
`define FLSR_BIT_PEERR 19
`define FLSR_BIT_ODS_LO 21
`define FLSR_BIT_PINSEL 23
`define FLSR_NV_MASK 24'he07bfc
`define FLSR_OTP_MASK 24'h003800
`define FLSR_VOL_MASK 24'h00027c
`define FLSR_NV_RESET 24'h400000

// ----------------------------------------
// Parameter table words, base address 64h/68h/6Ch
// ----------------------------------------
`define FLSR_PT_BASE 8'h64
`define FLSR_PT_LAST 8'h6f
`define FLSR_PT_W64 32'h5cd5a4f7
`define FLSR_PT_W68 32'hff5cd629
`define FLSR_PT_W6C 32'h80c030e9
`define FLSR_PT_BLANK 8'hff

// ----------------------------------------
// Timing
// ----------------------------------------
`define FLSR_CLK_NS 10
`define FLSR_NV_WRITE_NS 5000
`define FLSR_NV_WRITE_CYC (`FLSR_NV_WRITE_NS / `FLSR_CLK_NS)

`endif

// [flsr_link_sync.v]
// Two-flop synchronisers for the serial pins plus edge detection.
// Assumes pins are asynchronous to clk_i; edges come from the
// second flop only.
`timescale 1ns/1ps

module flsr_link_sync
(
    input wire clk_i,
    input wire rst_n_i,
    input wire sck_i,
    input wire cs_n_i,
    input wire si_i,
    output wire sck_rise_o,
    output wire sck_fall_o,
    output wire cs_n_o,
    output wire cs_rise_o,
    output wire cs_fall_o,
    output wire si_o
);

    reg [2:0] meta_q;
    reg [2:0] sync_q;
    reg [1:0] last_q;

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= 3'h2;
            sync_q <= 3'h2;
            last_q <= 2'h2;
        end
        else
        begin
            meta_q <= {si_i, cs_n_i, sck_i};
            sync_q <= meta_q;
            last_q <= sync_q[1:0];
        end
    end

    assign sck_rise_o = sync_q[0] & ~last_q[0];
    assign sck_fall_o = ~sync_q[0] & last_q[0];
    assign cs_n_o = sync_q[1];
    assign cs_rise_o = sync_q[1] & ~last_q[1];
    assign cs_fall_o = ~sync_q[1] & last_q[1];
    assign si_o = sync_q[2];

endmodule // flsr_link_sync

// [flsr_param_rom.v]
// Parameter table bytes 64h..6Fh; all other addresses read blank.
// Pure lookup, no state.
`timescale 1ns/1ps
`include "flsr_map.vh"

module flsr_param_rom
(
    input wire [7:0] addr_i,
    output reg [7:0] data_o
);

    reg [31:0] word;
    reg [7:0] offs;

    always @*
    begin
        word = 32'hffffffff;
        offs = addr_i - `FLSR_PT_BASE;
        data_o = `FLSR_PT_BLANK;
        if (addr_i >= `FLSR_PT_BASE && addr_i <= `FLSR_PT_LAST)
        begin
            if (offs[3:2] == 2'h0)
                word = `FLSR_PT_W64;
            else if (offs[3:2] == 2'h1)
                word = `FLSR_PT_W68;
            else
                word = `FLSR_PT_W6C;
            data_o = word[offs[1:0]*8 +: 8];
        end
    end

endmodule // flsr_param_rom

// [flsr_status_bank.v]
// Status and configuration register bank of a serial NOR flash.
// Assumes mode-0 serial framing on sck_i/cs_n_i/si_i, and an array
// engine on clk_i that reports busy, active operation and failure.
`timescale 1ns/1ps
`include "flsr_map.vh"

// Function
// - Three 8-bit status registers hold bits 0 to 23.
// - A write equal to the held value does not rewrite the cells.
// - Bit 0 is read-only busy: 1 during a write cycle.
// - Bit 1 is the volatile write-enable latch, default 0.
// - Bits 2-6 are block-protect bits, volatile and non-volatile.
// - Bits 7 and 8 are non-volatile register-protect bits.
// - Bit 9 is quad enable, volatile and non-volatile, default 0.
// - Bit 10 is read-only program-suspended flag.
// - Bits 11-13 are one-time lock bits for information registers.
// - Table reports power-down exit ABh and entry B9h codes.
// - Table reports power-down exit delay 00100b, units 01b.
// - Table reports quad mode enable 00010b and disable 1001b.
// - Table reports 0-4-4 supported, exit 110101b, entry 1100b.
// - Table reports quad-enable requirement 101b, hold disable 0b.
// - Table reports status volatility field 1101001b at 6Ch.
// - Table reports soft-reset support field 110000b.
// - Write-enable command sets the latch before guarded writes.
// - While busy only status reads, resets and suspend are taken.
// - Suspend during program sets the flag; resume clears it.
// - Quad enable turns protect and hold pins into data lines; this bank only drives it out on quad_enable_o for the pad logic.
module flsr_status_bank
#(
    parameter NV_WRITE_CYC = `FLSR_NV_WRITE_CYC
)
(
    input wire clk_i,
    input wire rst_n_i,
    input wire sck_i,
    input wire cs_n_i,
    input wire si_i,
    input wire array_busy_i,
    input wire program_active_i,
    input wire erase_active_i,
    input wire op_fail_i,
    output reg so_o,
    output reg so_oe_o,
    output reg busy_flag_o,
    output reg write_enable_latch_o,
    output reg [4:0] block_protect_o,
    output reg complement_protect_o,
    output reg [1:0] register_protect_o,
    output reg quad_enable_o,
    output reg [2:0] info_reg_lock_o,
    output reg [1:0] drive_strength_o,
    output reg reset_pin_select_o,
    output reg suspend_req_o,
    output reg resume_req_o,
    output reg soft_reset_o
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [7:0] byte_of;
        input [23:0] img;
        input [1:0] idx;
        begin
            byte_of = img[idx*8 +: 8];
        end
    endfunction

    function [23:0] place_byte;
        input [23:0] img;
        input [1:0] idx;
        input [7:0] val;
        reg [23:0] tmp;
        begin
            tmp = img;
            tmp[idx*8 +: 8] = val;
            place_byte = tmp;
        end
    endfunction

    function is_busy_ok;
        input [7:0] cmd;
        begin
            is_busy_ok = (cmd == `FLSR_CMD_RD_SR1) || (cmd == `FLSR_CMD_RD_SR2) ||
                (cmd == `FLSR_CMD_RD_SR3) || (cmd == `FLSR_CMD_RST_EN) ||
                (cmd == `FLSR_CMD_RST) || (cmd == `FLSR_CMD_SUSPEND);
        end
    endfunction

    // ----------------------------------------
    // Frame states, one-hot
    // ----------------------------------------
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_CMD = 5'h02;
    localparam [4:0] ST_READ = 5'h04;
    localparam [4:0] ST_WDATA = 5'h08;
    localparam [4:0] ST_PARAM = 5'h10;

    wire sck_rise;
    wire sck_fall;
    wire cs_n;
    wire cs_rise;
    wire cs_fall;
    wire si;
    wire [7:0] rom_data;
    wire [7:0] rx_byte;
    wire byte_done;

    reg [4:0] state_q;
    reg [2:0] bit_cnt_q;
    reg [2:0] byte_cnt_q;
    reg [6:0] rx_q;
    reg [7:0] tx_q;
    reg [7:0] cmd_q;
    reg [1:0] rd_idx_q;
    reg [7:0] addr_q;
    reg [7:0] wr_data_q;
    reg wr_valid_q;
    reg [1:0] wr_idx_q;
    reg wr_vol_q;
    reg vol_wen_q;
    reg rst_en_q;
    reg [23:0] nv_q;
    reg [23:0] pend_q;
    reg [4:0] vol_bp_q;
    reg vol_qe_q;
    reg nv_busy_q;
    reg [15:0] nv_cnt_q;
    reg busy_q;
    reg wel_q;
    reg program_suspended_q;
    reg erase_suspended_q;
    reg program_erase_error_q;
    reg array_busy_q;
    reg [23:0] sr_img;
    reg [23:0] wr_merge;
    reg [7:0] cur_byte;

    flsr_link_sync u_sync
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sck_i(sck_i),
        .cs_n_i(cs_n_i),
        .si_i(si_i),
        .sck_rise_o(sck_rise),
        .sck_fall_o(sck_fall),
        .cs_n_o(cs_n),
        .cs_rise_o(cs_rise),
        .cs_fall_o(cs_fall),
        .si_o(si)
    );

    flsr_param_rom u_rom
    (
        .addr_i(addr_q),
        .data_o(rom_data)
    );

    // ----------------------------------------
    // Readable image and write merge
    // ----------------------------------------
    always @*
    begin
        sr_img = 24'h000000;
        sr_img[`FLSR_BIT_BUSY] = busy_q;
        sr_img[`FLSR_BIT_WEL] = wel_q;
        sr_img[`FLSR_BIT_BP_LO +: 5] = vol_bp_q;
        sr_img[`FLSR_BIT_SRP_LO] = nv_q[`FLSR_BIT_SRP_LO];
        sr_img[`FLSR_BIT_SRP_HI] = nv_q[`FLSR_BIT_SRP_HI];
        sr_img[`FLSR_BIT_QE] = vol_qe_q;
        sr_img[`FLSR_BIT_PROGRAM_SUSPENDED] = program_suspended_q;
        sr_img[`FLSR_BIT_IRL_LO +: 3] = nv_q[`FLSR_BIT_IRL_LO +: 3];
        sr_img[`FLSR_BIT_CMP] = nv_q[`FLSR_BIT_CMP];
        sr_img[`FLSR_BIT_ERASE_SUSPENDED] = erase_suspended_q;
        sr_img[`FLSR_BIT_PEERR] = program_erase_error_q;
        sr_img[`FLSR_BIT_ODS_LO +: 3] = nv_q[`FLSR_BIT_ODS_LO +: 3];
    end

    always @*
    begin
        // Lock bits only ever set; reserved bits masked off
        wr_merge = place_byte(24'h000000, wr_idx_q, wr_data_q);
        wr_merge = (wr_merge & `FLSR_NV_MASK & ~`FLSR_OTP_MASK) |
            ((wr_merge | nv_q) & `FLSR_OTP_MASK) |
            (nv_q & ~`FLSR_NV_MASK);
        wr_merge = place_byte(nv_q, wr_idx_q, byte_of(wr_merge, wr_idx_q));
        cur_byte = byte_of(nv_q, wr_idx_q);
    end

    assign rx_byte = {rx_q, si};
    assign byte_done = sck_rise & ~cs_n & (bit_cnt_q == 3'h7);

    // ----------------------------------------
    // Serial framing
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
            rx_q <= 7'h00;
            tx_q <= 8'h00;
            cmd_q <= 8'h00;
            rd_idx_q <= 2'h0;
            addr_q <= 8'h00;
            wr_data_q <= 8'h00;
            wr_valid_q <= 1'b0;
            wr_idx_q <= 2'h0;
            wr_vol_q <= 1'b0;
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
        end
        else if (cs_n)
        begin
            state_q <= ST_IDLE;
            so_oe_o <= 1'b0;
            if (cs_rise)
                wr_valid_q <= 1'b0;
        end
        else
        begin
            if (cs_fall)
            begin
                state_q <= ST_CMD;
                bit_cnt_q <= 3'h0;
                byte_cnt_q <= 3'h0;
                wr_valid_q <= 1'b0;
            end
            if (sck_rise)
            begin
                rx_q <= rx_byte[6:0];
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (sck_fall)
            begin
                so_o <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
            if (byte_done)
            begin
                if (byte_cnt_q != 3'h7)
                    byte_cnt_q <= byte_cnt_q + 3'h1;
                case (state_q)
                    ST_CMD:
                    begin
                        cmd_q <= rx_byte;
                        state_q <= ST_IDLE;
                        if (!busy_q || is_busy_ok(rx_byte))
                        begin
                            if (rx_byte == `FLSR_CMD_RD_SR1 || rx_byte == `FLSR_CMD_RD_SR2 ||
                                rx_byte == `FLSR_CMD_RD_SR3)
                            begin
                                state_q <= ST_READ;
                                rd_idx_q <= (rx_byte == `FLSR_CMD_RD_SR1) ? 2'h0 :
                                    (rx_byte == `FLSR_CMD_RD_SR2) ? 2'h1 : 2'h2;
                                tx_q <= byte_of(sr_img, (rx_byte == `FLSR_CMD_RD_SR1) ?
                                    2'h0 : (rx_byte == `FLSR_CMD_RD_SR2) ? 2'h1 : 2'h2);
                                so_oe_o <= 1'b1;
                            end
                            else if (rx_byte == `FLSR_CMD_WR_SR1 ||
                                rx_byte == `FLSR_CMD_WR_SR2 || rx_byte == `FLSR_CMD_WR_SR3)
                            begin
                                state_q <= ST_WDATA;
                                wr_idx_q <= (rx_byte == `FLSR_CMD_WR_SR1) ? 2'h0 :
                                    (rx_byte == `FLSR_CMD_WR_SR2) ? 2'h1 : 2'h2;
                                wr_vol_q <= vol_wen_q;
                            end
                            else if (rx_byte == `FLSR_CMD_RD_PARAM)
                                state_q <= ST_PARAM;
                        end
                    end
                    ST_READ:
                    begin
                        // Polling: each byte gets a fresh snapshot
                        tx_q <= byte_of(sr_img, rd_idx_q);
                    end
                    ST_WDATA:
                    begin
                        // Extra bytes beyond the first are dropped
                        if (byte_cnt_q == 3'h1)
                        begin
                            wr_data_q <= rx_byte;
                            wr_valid_q <= 1'b1;
                        end
                    end
                    ST_PARAM:
                    begin
                        if (byte_cnt_q <= 3'h3)
                            addr_q <= rx_byte;
                        else if (byte_cnt_q == 3'h4)
                        begin
                            tx_q <= rom_data;
                            addr_q <= addr_q + 8'h01;
                            so_oe_o <= 1'b1;
                        end
                        else
                        begin
                            tx_q <= rom_data;
                            addr_q <= addr_q + 8'h01;
                        end
                    end
                    default:
                        state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Command completion and register update
    // ----------------------------------------
    wire frame_end_cmd;
    wire do_write;

    assign frame_end_cmd = cs_rise & (byte_cnt_q == 3'h1) & (state_q != ST_IDLE ||
        cmd_q != 8'h00);
    assign do_write = cs_rise & wr_valid_q;

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            nv_q <= `FLSR_NV_RESET;
            pend_q <= `FLSR_NV_RESET;
            vol_bp_q <= 5'h00;
            vol_qe_q <= 1'b0;
            nv_busy_q <= 1'b0;
            nv_cnt_q <= 16'h0000;
            busy_q <= 1'b0;
            wel_q <= 1'b0;
            vol_wen_q <= 1'b0;
            rst_en_q <= 1'b0;
            program_suspended_q <= 1'b0;
            erase_suspended_q <= 1'b0;
            program_erase_error_q <= 1'b0;
            array_busy_q <= 1'b0;
            suspend_req_o <= 1'b0;
            resume_req_o <= 1'b0;
            soft_reset_o <= 1'b0;
        end
        else
        begin
            suspend_req_o <= 1'b0;
            resume_req_o <= 1'b0;
            soft_reset_o <= 1'b0;
            array_busy_q <= array_busy_i;
            busy_q <= nv_busy_q | array_busy_i;

            // Program or erase finished: latch drops
            if (array_busy_q && !array_busy_i)
                wel_q <= 1'b0;

            // Failure sets win over the clear at op start
            if (op_fail_i)
                program_erase_error_q <= 1'b1;
            else if (array_busy_i && !array_busy_q)
                program_erase_error_q <= 1'b0;

            if (nv_busy_q)
            begin
                if (nv_cnt_q == 16'h0001)
                begin
                    nv_busy_q <= 1'b0;
                    nv_q <= pend_q;
                    vol_bp_q <= pend_q[`FLSR_BIT_BP_LO +: 5];
                    vol_qe_q <= pend_q[`FLSR_BIT_QE];
                    wel_q <= 1'b0;
                end
                nv_cnt_q <= nv_cnt_q - 16'h0001;
            end

            if (frame_end_cmd && (!busy_q || is_busy_ok(cmd_q)))
            begin
                rst_en_q <= (cmd_q == `FLSR_CMD_RST_EN);
                if (cmd_q == `FLSR_CMD_WRITE_ENABLE_COMMAND)
                    wel_q <= 1'b1;
                else if (cmd_q == `FLSR_CMD_WRDIS)
                    wel_q <= 1'b0;
                else if (cmd_q == `FLSR_CMD_VOL_WEN)
                    vol_wen_q <= 1'b1;
                else if (cmd_q == `FLSR_CMD_SUSPEND && busy_q)
                begin
                    suspend_req_o <= 1'b1;
                    if (program_active_i)
                        program_suspended_q <= 1'b1;
                    else if (erase_active_i)
                        erase_suspended_q <= 1'b1;
                end
                else if (cmd_q == `FLSR_CMD_RESUME && (program_suspended_q || erase_suspended_q))
                begin
                    resume_req_o <= 1'b1;
                    program_suspended_q <= 1'b0;
                    erase_suspended_q <= 1'b0;
                end
                else if (cmd_q == `FLSR_CMD_RST && rst_en_q)
                begin
                    // Volatile copies fall back to stored values
                    soft_reset_o <= 1'b1;
                    wel_q <= 1'b0;
                    vol_wen_q <= 1'b0;
                    program_suspended_q <= 1'b0;
                    erase_suspended_q <= 1'b0;
                    vol_bp_q <= nv_q[`FLSR_BIT_BP_LO +: 5];
                    vol_qe_q <= nv_q[`FLSR_BIT_QE];
                end
            end

            if (do_write && !busy_q)
            begin
                vol_wen_q <= 1'b0;
                if (wr_vol_q)
                begin
                    // Volatile path touches only BP and QE
                    if (wr_idx_q == 2'h0)
                        vol_bp_q <= wr_data_q[`FLSR_BIT_BP_LO +: 5];
                    else if (wr_idx_q == 2'h1)
                        vol_qe_q <= wr_data_q[`FLSR_BIT_QE - 8];
                end
                else if (wel_q)
                begin
                    if (byte_of(wr_merge, wr_idx_q) == cur_byte)
                        wel_q <= 1'b0;
                    else
                    begin
                        pend_q <= wr_merge;
                        nv_busy_q <= 1'b1;
                        busy_q <= 1'b1;
                        nv_cnt_q <= NV_WRITE_CYC[15:0];
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Registered control outputs
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_flag_o <= 1'b0;
            write_enable_latch_o <= 1'b0;
            block_protect_o <= 5'h00;
            complement_protect_o <= 1'b0;
            register_protect_o <= 2'h0;
            quad_enable_o <= 1'b0;
            info_reg_lock_o <= 3'h0;
            drive_strength_o <= 2'h2;
            reset_pin_select_o <= 1'b0;
        end
        else
        begin
            busy_flag_o <= busy_q;
            write_enable_latch_o <= wel_q;
            block_protect_o <= vol_bp_q;
            complement_protect_o <= nv_q[`FLSR_BIT_CMP];
            register_protect_o <= nv_q[`FLSR_BIT_SRP_LO +: 2];
            // Pad logic uses this to turn protect/hold into IO2/IO3
            quad_enable_o <= vol_qe_q;
            info_reg_lock_o <= nv_q[`FLSR_BIT_IRL_LO +: 3];
            drive_strength_o <= nv_q[`FLSR_BIT_ODS_LO +: 2];
            reset_pin_select_o <= nv_q[`FLSR_BIT_PINSEL];
        end
    end

endmodule // flsr_status_bank

// [flsr_host_model.sv]
// Host serial master model: mode-0 frames, MSB first, 80 ns bit time.
// Assumes a 10 ns clk_i; a released si shows the inverse of its last bit.
`timescale 1ns/1ps
module flsr_host_model
(
    input wire clk_i,
    input wire so_i,
    output reg sck_o = 1'b0,
    output reg cs_n_o = 1'b1,
    output reg si_o = 1'b0
);
    // Sample late in the high phase, clear of the output lag
    task xfer(input [7:0] tx, output [7:0] rx);
        integer i;
        for (i = 7; i >= 0; i = i - 1)
        begin
            cs_n_o <= 1'b0;
            si_o <= tx[i];
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            rx[i] = so_i;
            sck_o <= 1'b0;
        end
    endtask
    task stop;
        begin
            repeat (4) @(posedge clk_i);
            cs_n_o <= 1'b1;
            si_o <= ~si_o;
            repeat (8) @(posedge clk_i);
        end
    endtask
endmodule // flsr_host_model

// [flsr_status_bank_chk.sv]
// Pin-level checks of the status bank, bound onto its top module.
// Assumes one clock domain with an async active-low reset.
`timescale 1ns/1ps
module flsr_status_bank_chk #(parameter NV_WRITE_CYC = 500)
(
    input wire clk_i,
    input wire rst_n_i,
    input wire cs_n_i,
    input wire array_busy_i,
    input wire so_oe_o,
    input wire busy_flag_o,
    input wire write_enable_latch_o,
    input wire [2:0] info_reg_lock_o,
    input wire suspend_req_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    busy_track_a: assert property (array_busy_i [*3] |-> busy_flag_o)
        else $error("busy flag low");
    wel_busy_a: assert property ($rose(write_enable_latch_o) |-> !$past(busy_flag_o))
        else $error("latch set while busy");
    wel_clear_a: assert property ($fell(array_busy_i) |-> ##[1:3] !write_enable_latch_o)
        else $error("latch kept");
    susp_busy_a: assert property (suspend_req_o |-> busy_flag_o)
        else $error("suspend while idle");
    susp_pulse_a: assert property (suspend_req_o |=> !suspend_req_o)
        else $error("suspend pulse long");
    oe_idle_a: assert property (cs_n_i [*6] |-> !so_oe_o)
        else $error("drive outside frame");
    oe_frame_a: assert property ($rose(so_oe_o) |-> !cs_n_i)
        else $error("drive unselected");
    lock_sticky_a: assert property (($past(info_reg_lock_o) & ~info_reg_lock_o) == 3'h0)
        else $error("lock cleared");
    cover property ($rose(busy_flag_o));
    cover property (suspend_req_o);
    cover property ($rose(write_enable_latch_o));
endmodule // flsr_status_bank_chk

// [flsr_status_bank_tb.sv]
// Bench for the status register bank, driven through its serial pins.
// Assumes the host model for framing; the array engine is modelled here.
`timescale 1ns/1ps
module flsr_status_bank_tb;
    reg clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg abusy = 1'b0;
    reg [2:0] seen = 3'h0;
    reg [7:0] v;
    reg [103:0] p;
    integer fails = 0, compares = 0, k;
    wire sck, cs_n, si, so, oe, busy, write_enable_latch, qe, psel, susp, resm, cmp, srst;
    wire [4:0] bp;
    wire [1:0] srp, ds;
    wire [2:0] lock;
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) seen <= seen | {srst, resm, susp};
    flsr_host_model i_flsr_host_model (.clk_i(clk_i), .so_i(so), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));
    flsr_status_bank #(.NV_WRITE_CYC(200)) i_flsr_status_bank (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .array_busy_i(abusy), .program_active_i(abusy),
        .erase_active_i(1'b0), .op_fail_i(1'b0), .so_o(so), .so_oe_o(oe), .busy_flag_o(busy),
        .write_enable_latch_o(write_enable_latch), .block_protect_o(bp), .complement_protect_o(cmp),
        .register_protect_o(srp), .quad_enable_o(qe), .info_reg_lock_o(lock), .drive_strength_o(ds),
        .reset_pin_select_o(psel), .suspend_req_o(susp), .resume_req_o(resm), .soft_reset_o(srst));
    // ------------------------
    // Access tasks
    // ------------------------
    task check(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            fails = fails + (got !== exp);
            if (got !== exp)
                $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task frame(input [7:0] c, input [7:0] d, input two);
        begin
            i_flsr_host_model.xfer(c, v);
            if (two)
                i_flsr_host_model.xfer(d, v);
            i_flsr_host_model.stop;
        end
    endtask
    task rd(input [7:0] c, input [7:0] exp);
        begin
            frame(c, 8'h00, 1'b1);
            check(v, exp);
        end
    endtask
    task close_out;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // Non-volatile writes take 200 cycles here, so waits of 220 cover them
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(8'h05, 8'h00);
        rd(8'h35, 8'h00);
        rd(8'h15, 8'h40);
        frame(8'h06, 8'h00, 1'b0);
        check(write_enable_latch, 1'b1);
        frame(8'h01, 8'hfc, 1'b1);
        check(busy, 1'b1);
        rd(8'h05, 8'h03);
        repeat (220) @(posedge clk_i);
        check({busy, write_enable_latch, srp, bp}, 9'h03f);
        frame(8'h06, 8'h00, 1'b0);
        frame(8'h01, 8'hfc, 1'b1);
        check({busy, write_enable_latch}, 2'h0);
        frame(8'h01, 8'h00, 1'b1);
        rd(8'h05, 8'hfc);
        frame(8'h50, 8'h00, 1'b0);
        frame(8'h31, 8'h02, 1'b1);
        repeat (220) @(posedge clk_i);
        check(qe, 1'b1);
        frame(8'h06, 8'h00, 1'b0);
        frame(8'h11, 8'hff, 1'b1);
        repeat (220) @(posedge clk_i);
        rd(8'h15, 8'he0);
        frame(8'h06, 8'h00, 1'b0);
        frame(8'h31, 8'h78, 1'b1);
        repeat (220) @(posedge clk_i);
        check({lock, psel, ds, cmp}, 7'h7f);
        // Clearing the locks must fail while the compare bit still clears
        frame(8'h06, 8'h00, 1'b0);
        frame(8'h31, 8'h00, 1'b1);
        repeat (220) @(posedge clk_i);
        check({lock, cmp}, 4'he);
        abusy <= 1'b1;
        frame(8'h06, 8'h00, 1'b0);
        check(write_enable_latch, 1'b0);
        frame(8'h75, 8'h00, 1'b0);
        rd(8'h35, 8'h3c);
        abusy <= 1'b0;
        frame(8'h7a, 8'h00, 1'b0);
        rd(8'h35, 8'h38);
        check(seen, 2'h3);
        frame(8'h50, 8'h00, 1'b0);
        frame(8'h31, 8'h02, 1'b1);
        check(qe, 1'b1);
        frame(8'h06, 8'h00, 1'b0);
        frame(8'h04, 8'h00, 1'b0);
        check(write_enable_latch, 1'b0);
        // Soft reset reloads volatile copies from the stored ones
        frame(8'h66, 8'h00, 1'b0);
        frame(8'h99, 8'h00, 1'b0);
        check({seen, qe, bp}, 9'h1df);
        for (k = 0; k < 5; k = k + 1)
            i_flsr_host_model.xfer(k == 0 ? 8'h5a : (k == 3 ? 8'h64 : 8'h00), v);
        for (k = 0; k < 13; k = k + 1)
        begin
            i_flsr_host_model.xfer(8'h00, v);
            p[8*k +: 8] = v;
        end
        i_flsr_host_model.stop;
        check(p[30:8], {8'hb9, 8'hab, 2'b01, 5'b00100});
        check(p[55:32], 24'h5cd629);
        check({p[77:72], p[70:64]}, {6'b110000, 7'b1101001});
        check(p[103:96], 8'hff);
        close_out;
    end
endmodule // flsr_status_bank_tb

bind flsr_status_bank flsr_status_bank_chk #(.NV_WRITE_CYC(NV_WRITE_CYC)) i_flsr_status_bank_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .array_busy_i(array_busy_i),
    .so_oe_o(so_oe_o), .busy_flag_o(busy_flag_o), .write_enable_latch_o(write_enable_latch_o),
    .info_reg_lock_o(info_reg_lock_o), .suspend_req_o(suspend_req_o));
